// file: pss_regs.sv
// Overview of operation
// - The pin-level register is at 31h, resets to 0001h, only bit 0 writable, bits 15..1 read zero.
// - Writing 0, or writing 1 with open-drain disabled, makes the general-purpose pin an output driven from that value.
// - Writing 1 releases the pin when open-drain is enabled and drives it high otherwise.
// - Writing 0 drives the pin low regardless of open-drain setting.
// - Reading the pin-level bit returns the sensed pin level, not the stored value.
// - After start-up a low pin reads as 0 although the stored default is 1.
// - After any reset the pin stays high impedance until software writes the pin-level bit.
// - The short-status register is at 32h, read-only in all sixteen bits, reset 0000h.
// - Bit n of short-status reports whether channel n is shorted to ground, bits 15..12 for channels 15..12.
// - A short flag reads 1 while its channel is shorted and 0 otherwise.
// - Bits 11..0 use the same encoding for channels 11..0.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

module pss_regs (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     ce_in,
  // Register port
  input  wire logic [`PSS_ADDR_W-1:0]   addr_in,
  input  wire logic [`PSS_DATA_W-1:0]   wdata_in,
  input  wire logic                     wr_in,
  input  wire logic                     rd_in,
  output logic      [`PSS_DATA_W-1:0]   rdata_out,
  // Configuration
  input  wire logic                     open_drain_enable_in,
  // General-purpose pin
  input  wire logic                     gp_pin_in,
  output logic                          gp_pin_out,
  output logic                          gp_pin_oe_out,
  // Channel short detectors
  input  wire logic [`PSS_NUM_CH-1:0]   short_det_in
);
  import pss_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic                   pin_sync;
  logic [`PSS_NUM_CH-1:0] short_sync;

  pss_sync #(.W(1)) u_pin_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   (gp_pin_in),
    .sync_out   (pin_sync)
  );

  pss_sync #(.W(`PSS_NUM_CH)) u_short_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   (short_det_in),
    .sync_out   (short_sync)
  );

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  // Reset word of the pin-level register and its one stored bit
  localparam logic [`PSS_DATA_W-1:0] PIN_RESET_WORD = `PSS_PIN_RESET;
  localparam logic                   PIN_RESET_BIT  = PIN_RESET_WORD[`PSS_PIN_BIT];

  logic                   pin_bit_r;
  logic                   pin_bit_nxt;
  logic                   pin_written_r;
  logic                   pin_written_nxt;
  pss_pin_mode_t          mode_r;
  pss_pin_mode_t          mode_nxt;
  logic [`PSS_NUM_CH-1:0] short_r;
  logic [`PSS_NUM_CH-1:0] short_nxt;
  logic [`PSS_DATA_W-1:0] rdata_r;
  logic [`PSS_DATA_W-1:0] rdata_nxt;
  logic                   pin_wr;
  logic                   pin_rd;
  logic                   short_rd;

  // Address match helper
  function automatic logic hit(input logic [`PSS_ADDR_W-1:0] a,
                               input logic [`PSS_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Decoded, enabled bus strobes
  assign pin_wr   = ce_in && wr_in && hit(addr_in, `PSS_PIN_OFFSET);
  assign pin_rd   = ce_in && rd_in && hit(addr_in, `PSS_PIN_OFFSET);
  assign short_rd = ce_in && rd_in && hit(addr_in, `PSS_SHORT_OFFSET);

  // ------------------------------------------------------------
  // Pin state
  // ------------------------------------------------------------
  // Next values: only a write to the pin register moves them
  always_comb begin
    pin_bit_nxt     = pin_bit_r;
    pin_written_nxt = pin_written_r;
    mode_nxt        = mode_r;
    if (pin_wr) begin
      pin_bit_nxt     = wdata_in[`PSS_PIN_BIT];
      pin_written_nxt = 1'b1;
      if (!wdata_in[`PSS_PIN_BIT]) begin
        mode_nxt = PSS_PIN_LOW;
      end else if (open_drain_enable_in) begin
        mode_nxt = PSS_PIN_HIZ;
      end else begin
        mode_nxt = PSS_PIN_HIGH;
      end
    end
  end

  // Registers; reset releases the pin until the next write
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_bit_r     <= PIN_RESET_BIT;
      pin_written_r <= 1'b0;
      mode_r        <= PSS_PIN_HIZ;
    end else begin
      pin_bit_r     <= pin_bit_nxt;
      pin_written_r <= pin_written_nxt;
      mode_r        <= mode_nxt;
    end
  end

  // ------------------------------------------------------------
  // Short status
  // ------------------------------------------------------------
  // Next values: live copy of the synchronised detectors
  always_comb begin
    short_nxt = short_r;
    if (ce_in) begin
      short_nxt = short_sync;
    end
  end

  // Registers; bus writes never reach these flags
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      short_r <= `PSS_SHORT_RESET;
    end else begin
      short_r <= short_nxt;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Next values: zero unless a mapped register is read
  always_comb begin
    rdata_nxt = rdata_r;
    if (ce_in) begin
      rdata_nxt = `PSS_ZERO_DATA;
      if (pin_rd) begin
        rdata_nxt[`PSS_PIN_BIT] = pin_sync;
      end else if (short_rd) begin
        rdata_nxt = short_r;
      end
    end
  end

  // Registers; data stands for one cycle while ce_in is high and holds while it is low
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_r <= `PSS_ZERO_DATA;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Pin driver
  // ------------------------------------------------------------
  pss_pin_drv u_pin_drv (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .mode_in    (mode_r),
    .pin_o_out  (gp_pin_out),
    .pin_oe_out (gp_pin_oe_out)
  );

  assign rdata_out = rdata_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  // Pin stays released until the first write
  a_pin_hiz_reset: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !pin_written_r |-> !gp_pin_oe_out)
    else $error("pin driven before any write");

  // Written 0 drives low two cycles on
  a_pin_low_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && !wdata_in[`PSS_PIN_BIT]) ##1 ce_in |=> (gp_pin_oe_out && !gp_pin_out))
    else $error("write 0 did not drive low");

  // Written 1 with open drain releases the pin
  a_pin_od_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && wdata_in[`PSS_PIN_BIT] && open_drain_enable_in) ##1 ce_in |=> !gp_pin_oe_out)
    else $error("open drain 1 not released");

  // Written 1 in push-pull drives high
  a_pin_high_drive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && wdata_in[`PSS_PIN_BIT] && !open_drain_enable_in) ##1 ce_in |=> (gp_pin_oe_out && gp_pin_out))
    else $error("push-pull 1 not driven high");

  // Pin read returns the sensed level
  a_pin_read_sense: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && rd_in && addr_in == `PSS_PIN_OFFSET) |=> (rdata_out == {15'h0000, $past(pin_sync)}))
    else $error("pin read not sensed level");

  // Short status read returns the flags
  a_short_read_val: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && rd_in && addr_in == `PSS_SHORT_OFFSET) |=> (rdata_out == $past(short_r)))
    else $error("short status read mismatch");

  // Reserved pin-level bits read as zero
  a_pin_rsvd_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_rd |=> (rdata_out[`PSS_DATA_W-1:`PSS_PIN_BIT+1] == '0))
    else $error("reserved pin bits not zero");

  // Stored bit keeps the written value
  a_pin_bit_store: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_wr |=> (pin_bit_r == $past(wdata_in[`PSS_PIN_BIT])))
    else $error("pin bit not stored");

  // Any pin write arms the output
  a_pin_written_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    pin_wr |=> pin_written_r)
    else $error("pin write not recorded");

  // Mode after a 0 write
  a_pin_mode_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && !wdata_in[`PSS_PIN_BIT]) |=> (mode_r == PSS_PIN_LOW))
    else $error("mode not low after 0 write");

  // Mode after a 1 write with open drain
  a_pin_mode_hiz: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && wdata_in[`PSS_PIN_BIT] && open_drain_enable_in) |=> (mode_r == PSS_PIN_HIZ))
    else $error("mode not released after 1 write");

  // Mode after a 1 write in push-pull
  a_pin_mode_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (pin_wr && wdata_in[`PSS_PIN_BIT] && !open_drain_enable_in) |=> (mode_r == PSS_PIN_HIGH))
    else $error("mode not high after 1 write");

  // Drive enable follows the mode one cycle later
  a_pin_drv_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in |=> (gp_pin_oe_out == ($past(mode_r) != PSS_PIN_HIZ)))
    else $error("pin enable not following mode");

  // Drive value follows the mode one cycle later
  a_pin_drv_value: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in |=> (gp_pin_out == ($past(mode_r) == PSS_PIN_HIGH)))
    else $error("pin value not following mode");

  // Mode register always holds one legal code
  a_pin_mode_legal: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $onehot(mode_r))
    else $error("illegal pin mode code");

  // Frozen clock enable leaves the pin state alone
  a_pin_frozen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ce_in |=> ($stable(mode_r) && $stable(pin_written_r)))
    else $error("pin state moved while frozen");

  // Reset releases the pin state
  a_pin_rst_state: assert property (@(posedge clk_in)
    sys_rst_in |=> (!pin_written_r && mode_r == PSS_PIN_HIZ))
    else $error("reset did not release pin state");

  // Reset turns the pin driver off
  a_pin_rst_drv: assert property (@(posedge clk_in)
    sys_rst_in |=> !gp_pin_oe_out)
    else $error("reset left pin driven");

  // Reset clears the short flags
  a_short_rst_zero: assert property (@(posedge clk_in)
    sys_rst_in |=> (short_r == `PSS_SHORT_RESET))
    else $error("short flags not cleared by reset");

  // Reset clears the read data
  a_rdata_rst_zero: assert property (@(posedge clk_in)
    sys_rst_in |=> (rdata_out == `PSS_ZERO_DATA))
    else $error("read data not cleared by reset");

  // Read data is zero outside read answers
  a_rdata_idle_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && !rd_in) |=> (rdata_out == `PSS_ZERO_DATA))
    else $error("read data not zero when idle");

  // Unmapped reads return zero
  a_unmapped_read: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && rd_in && !pin_rd && !short_rd) |=> (rdata_out == `PSS_ZERO_DATA))
    else $error("unmapped read not zero");

  // Frozen clock enable holds the short flags
  a_short_frozen: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !ce_in |=> $stable(short_r))
    else $error("short flags moved while frozen");

  // A write to short status does not land
  a_short_no_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && wr_in && addr_in == `PSS_SHORT_OFFSET) |=> (short_r == $past(short_sync)))
    else $error("write reached short flags");

  a_short_tracks_in: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    ce_in |=> (short_r == $past(short_sync)))
    else $error("short flags not tracking detectors");

  a_ro_write_ignore: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && wr_in && addr_in != `PSS_PIN_OFFSET) |=> $stable(mode_r) && $stable(pin_bit_r))
    else $error("stray write changed pin state");
endmodule
`default_nettype wire

// file: pss_defs.svh
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define PSS_ADDR_W        8
`define PSS_DATA_W        16
`define PSS_PIN_OFFSET    8'h31
`define PSS_SHORT_OFFSET  8'h32
`define PSS_PIN_RESET     16'h0001
`define PSS_SHORT_RESET   16'h0000
`define PSS_PIN_BIT       0
`define PSS_NUM_CH        16
`define PSS_ZERO_DATA     16'h0000

`endif

// file: pss_pkg.sv
package pss_pkg;
  // Pin driver modes
  typedef enum logic [2:0] {
    PSS_PIN_HIZ  = 3'b001,
    PSS_PIN_LOW  = 3'b010,
    PSS_PIN_HIGH = 3'b100
  } pss_pin_mode_t;
endpackage

// file: pss_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

// Two-flop synchroniser for a bus of asynchronous levels
module pss_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Next values: hold when frozen
  always_comb begin
    meta_nxt = ce_in ? async_in : meta_r;
    sync_nxt = ce_in ? meta_r : sync_r;
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule
`default_nettype wire

// file: pss_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

// Pin driver: turns mode into output value and enable flops
module pss_pin_drv (
  input  wire logic                   clk_in,
  input  wire logic                   sys_rst_in,
  input  wire logic                   ce_in,
  input  wire pss_pkg::pss_pin_mode_t mode_in,
  output logic                        pin_o_out,
  output logic                        pin_oe_out
);
  import pss_pkg::*;

  logic pin_o_r;
  logic pin_o_nxt;
  logic pin_oe_r;
  logic pin_oe_nxt;

  // Decode mode; high-Z keeps value low with enable off
  always_comb begin
    pin_o_nxt  = pin_o_r;
    pin_oe_nxt = pin_oe_r;
    if (ce_in) begin
      pin_o_nxt  = (mode_in == PSS_PIN_HIGH);
      pin_oe_nxt = (mode_in != PSS_PIN_HIZ);
    end
  end

  // Registers; reset releases the pin
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_o_r  <= 1'b0;
      pin_oe_r <= 1'b0;
    end else begin
      pin_o_r  <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  assign pin_o_out  = pin_o_r;
  assign pin_oe_out = pin_oe_r;
endmodule
`default_nettype wire

// file: pss_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Board side of the general-purpose pin
// ------------------------------------------------------------
module pss_pin_model (
  // Device pin driver
  input  wire logic pin_o_in,
  input  wire logic pin_oe_in,
  // External open-collector pulling low
  input  wire logic ext_low_in,
  // Level seen on the wire
  output logic      level_out
);
  // Pull-up when released; a low from either side wins
  assign level_out = pin_oe_in ? (pin_o_in & ~ext_low_in) : ~ext_low_in;
endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pss_defs.svh"

// ------------------------------------------------------------
// Register bank bench
// ------------------------------------------------------------
module testbench;
  logic                   clk_in = 1'b0;
  logic                   rst    = 1'b1;
  logic                   ce     = 1'b1;
  logic [`PSS_ADDR_W-1:0] addr   = 8'h00;
  logic [`PSS_DATA_W-1:0] wdata  = 16'h0000;
  logic                   wr     = 1'b0;
  logic                   rd     = 1'b0;
  logic                   ode    = 1'b0;
  logic                   ext    = 1'b0;
  logic [`PSS_NUM_CH-1:0] shrt   = 16'h0000;
  logic [`PSS_DATA_W-1:0] rdata;
  logic                   pin_o, pin_oe, lvl, rd_d;
  logic [15:0]            lfsr = 16'h0021;
  logic [15:0]            exp_q[$];
  int                     err_count = 0;
  int                     checks = 0;

  // Clock
  always #5 clk_in = ~clk_in;

  pss_regs i_dut (.clk_in(clk_in), .sys_rst_in(rst), .ce_in(ce), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .open_drain_enable_in(ode), .gp_pin_in(lvl),
    .gp_pin_out(pin_o), .gp_pin_oe_out(pin_oe), .short_det_in(shrt));
  pss_pin_model i_pin (.pin_o_in(pin_o), .pin_oe_in(pin_oe), .ext_low_in(ext), .level_out(lvl));

  // Pseudo-random source
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic test_done();
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One bus cycle, launched on the current edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask

  // Read with its expected answer noted
  task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic chk_pin(input logic e_oe, input logic e_o);
    checks++;
    if ({pin_oe, pin_o & pin_oe} !== {e_oe, e_o & e_oe}) begin
      err_count++;
      $display("MISMATCH t=%0t pin got %h exp %h", $time, {pin_oe, pin_o}, {e_oe, e_o});
    end
  endtask

  // Read-data monitor
  always @(posedge clk_in) rd_d <= rd & ce & ~rst;
  always @(negedge clk_in) begin
    if (rd_d === 1'b1) begin
      checks++;
      if (exp_q.size() == 0 || rdata !== exp_q[0]) begin
        err_count++;
        $display("MISMATCH t=%0t rdata got %h exp %h", $time, rdata, exp_q.size() ? exp_q[0] : 16'hdead);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end

  // Watchdog
  initial begin
    repeat (100000) @(posedge clk_in);
    err_count++;
    test_done();
  end

  // Main sequence
  initial begin
    logic d;
    logic [15:0] v;
    repeat (16) @(posedge clk_in);
    rst <= 1'b0;
    chk_pin(1'b0, 1'b0);
    rd_exp(8'h32, 16'h0000);
    rd_exp(8'h40, 16'h0000);
    rd_exp(8'h31, 16'h0001);
    ext <= 1'b1;
    idle(5);
    rd_exp(8'h31, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      d = i[0];
      ode <= i[1];
      ext <= lfsr[0];
      bus(1'b1, 1'b0, 8'h31, {lfsr[15:1], d});
      idle(6);
      chk_pin(~d | ~i[1], d);
      rd_exp(8'h31, {15'h0000, d & ~lfsr[0]});
    end
    ce <= 1'b0;
    bus(1'b1, 1'b0, 8'h31, 16'h0000);
    ce <= 1'b1;
    bus(1'b1, 1'b0, 8'h32, 16'hffff);
    idle(4);
    chk_pin(1'b0, 1'b0);
    for (int i = 0; i < 22; i++) begin
      lfsr = nxt(lfsr);
      v = (i < 16) ? (16'h0001 << i) : lfsr;
      shrt <= v;
      idle(4);
      bus(1'b1, 1'b0, 8'h32, ~v);
      rd_exp(8'h32, v);
    end
    bus(1'b1, 1'b0, 8'h31, 16'h0000);
    idle(3);
    chk_pin(1'b1, 1'b0);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    ext <= 1'b0;
    idle(3);
    chk_pin(1'b0, 1'b0);
    rd_exp(8'h31, 16'h0001);
    idle(3);
    if (exp_q.size() != 0) err_count++;
    test_done();
  end
endmodule

`default_nettype wire
